/* hw/ioexp_top.sv */
`include "ioexp_regs.svh"

module ioexp_top (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    input  wire logic       i_bus_reset_n,
    input  wire logic       i_address_select_low,
    input  wire logic       i_address_select_high,
    input  wire logic [7:0] i_open_drain_pins,
    output logic [7:0]      o_open_drain_pins,
    output logic [7:0]      o_open_drain_pins_oe,
    input  wire logic [7:0] i_push_pull_pins,
    output logic [7:0]      o_push_pull_pins,
    output logic [7:0]      o_push_pull_pins_oe,
    output logic            o_change_alert_n,
    output logic            o_change_alert_n_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Input conditioning

    logic       scl;
    logic       sda;
    logic       rst_n;
    logic       sel_lo;
    logic       sel_hi;
    logic [7:0] od_lvl;
    logic [7:0] pp_lvl;

    ioexp_sync u_sync_scl (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_pin   (i_scl),
        .o_level (scl)
    );
    ioexp_sync u_sync_sda (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_pin   (i_sda),
        .o_level (sda)
    );
    ioexp_sync u_sync_rst (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_pin   (i_bus_reset_n),
        .o_level (rst_n)
    );
    ioexp_sync u_sync_sel_lo (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_pin   (i_address_select_low),
        .o_level (sel_lo)
    );
    ioexp_sync u_sync_sel_hi (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_pin   (i_address_select_high),
        .o_level (sel_hi)
    );

    // Port pins use three-stage sampling with the same two-stage agreement spike filter
    logic [7:0] od_s1, od_s2, od_s3;
    logic [7:0] pp_s1, pp_s2, pp_s3;
    logic [7:0] od_keep, pp_keep;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            od_s1   <= 8'h00;
            od_s2   <= 8'h00;
            od_s3   <= 8'h00;
            pp_s1   <= 8'h00;
            pp_s2   <= 8'h00;
            pp_s3   <= 8'h00;
            od_keep <= 8'h00;
            pp_keep <= 8'h00;
        end else begin
            od_s1   <= i_open_drain_pins;
            od_s2   <= od_s1;
            od_s3   <= od_s2;
            pp_s1   <= i_push_pull_pins;
            pp_s2   <= pp_s1;
            pp_s3   <= pp_s2;
            od_keep <= od_lvl;
            pp_keep <= pp_lvl;
        end
    end

    // A bit moves only when the later two stages agree
    assign od_lvl = (od_s2 & od_s3) | (od_keep & (od_s2 ^ od_s3));
    assign pp_lvl = (pp_s2 & pp_s3) | (pp_keep & (pp_s2 ^ pp_s3));

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        ioexp_pkg::ioexp_state_e fsm;
        logic                    scl_d;
        logic                    sda_d;
        logic [3:0]              bitcnt;
        ioexp_pkg::ioexp_byte_t  shift;
        logic                    rw;
        logic                    have_cmd;
        logic [2:0]              cmd;
        logic                    ack_drv;
        logic                    sda_drv;
        logic                    boot;
        ioexp_pkg::ioexp_byte_t  od_out;
        ioexp_pkg::ioexp_byte_t  pp_out;
        ioexp_pkg::ioexp_byte_t  od_dir;
        ioexp_pkg::ioexp_byte_t  pp_dir;
        ioexp_pkg::ioexp_byte_t  od_mask;
        ioexp_pkg::ioexp_byte_t  pp_mask;
        logic                    snap_od;
        logic                    snap_pp;
    } ioexp_top_s;

    ioexp_top_s st;
    ioexp_top_s next_st;

    logic       od_pend;
    logic       pp_pend;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic [6:0] my_addr;
    logic [7:0] rd_data;
    logic [7:0] boot_val;

    assign scl_rise   = scl & ~st.scl_d;
    assign scl_fall   = ~scl & st.scl_d;
    assign start_cond = scl & st.scl_d & st.sda_d & ~sda;
    assign stop_cond  = scl & st.scl_d & ~st.sda_d & sda;
    assign my_addr    = {`IOEXP_ADDR_FIXED, sel_hi, sel_lo};
    assign boot_val   = {sel_hi ? `IOEXP_NIBBLE_ONES : `IOEXP_NIBBLE_ZEROS,
                         sel_lo ? `IOEXP_NIBBLE_ONES : `IOEXP_NIBBLE_ZEROS};

    // Read mux, snapshot taken at the address acknowledge
    always_comb begin
        case (st.cmd)
            `IOEXP_CMD_OD_LEVELS: rd_data = od_lvl;
            `IOEXP_CMD_PP_LEVELS: rd_data = pp_lvl;
            `IOEXP_CMD_OD_OUT:    rd_data = st.od_out;
            `IOEXP_CMD_PP_OUT:    rd_data = st.pp_out;
            `IOEXP_CMD_OD_DIR:    rd_data = st.od_dir;
            `IOEXP_CMD_PP_DIR:    rd_data = st.pp_dir;
            `IOEXP_CMD_OD_MASK:   rd_data = st.od_mask;
            `IOEXP_CMD_PP_MASK:   rd_data = st.pp_mask;
            default:              rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine

    always_comb begin
        next_st         = st;
        next_st.scl_d   = scl;
        next_st.sda_d   = sda;
        next_st.snap_od = 1'b0;
        next_st.snap_pp = 1'b0;
        // Address selects are loaded in the first cycle after reset, from the level reset preloads from the pin
        if (st.boot) begin
            next_st.od_out = boot_val;
            next_st.pp_out = boot_val;
            next_st.boot   = 1'b0;
        end
        if (!rst_n) begin
            next_st.fsm     = ioexp_pkg::ST_IDLE;
            next_st.ack_drv = 1'b0;
            next_st.sda_drv = 1'b0;
        end else if (start_cond) begin
            next_st.fsm     = ioexp_pkg::ST_ADDR;
            next_st.bitcnt  = 4'h0;
            next_st.ack_drv = 1'b0;
            next_st.sda_drv = 1'b0;
        end else if (stop_cond) begin
            next_st.fsm     = ioexp_pkg::ST_IDLE;
            next_st.ack_drv = 1'b0;
            next_st.sda_drv = 1'b0;
        end else begin
            case (st.fsm)
                ioexp_pkg::ST_IDLE, ioexp_pkg::ST_IGNORE: begin
                end
                ioexp_pkg::ST_ADDR, ioexp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        next_st.shift  = {st.shift[6:0], sda};
                        next_st.bitcnt = st.bitcnt + 4'h1;
                    end else if (scl_fall && st.bitcnt == 4'h8) begin
                        next_st.bitcnt = 4'h0;
                        if (st.fsm == ioexp_pkg::ST_ADDR) begin
                            if (st.shift[7:1] == my_addr) begin
                                next_st.rw      = st.shift[0];
                                next_st.ack_drv = 1'b1;
                                next_st.fsm     = ioexp_pkg::ST_ACK;
                                next_st.have_cmd = 1'b0;
                                if (st.shift[0]) begin
                                    // Read of a group's levels or output register clears that group's flag at the ack
                                    next_st.snap_od = (st.cmd == `IOEXP_CMD_OD_LEVELS) ||
                                                      (st.cmd == `IOEXP_CMD_OD_OUT);
                                    next_st.snap_pp = (st.cmd == `IOEXP_CMD_PP_LEVELS) ||
                                                      (st.cmd == `IOEXP_CMD_PP_OUT);
                                end
                            end else begin
                                next_st.fsm = ioexp_pkg::ST_IGNORE;
                            end
                        end else if (!st.have_cmd) begin
                            // Commands above the map are not acknowledged
                            if (st.shift <= `IOEXP_CMD_LAST) begin
                                next_st.cmd      = st.shift[2:0];
                                next_st.have_cmd = 1'b1;
                                next_st.ack_drv  = 1'b1;
                                next_st.fsm      = ioexp_pkg::ST_ACK;
                            end else begin
                                next_st.fsm = ioexp_pkg::ST_IGNORE;
                            end
                        end else begin
                            case (st.cmd)
                                `IOEXP_CMD_OD_OUT:  next_st.od_out  = st.shift;
                                `IOEXP_CMD_PP_OUT:  next_st.pp_out  = st.shift;
                                `IOEXP_CMD_OD_DIR:  next_st.od_dir  = st.shift;
                                `IOEXP_CMD_PP_DIR:  next_st.pp_dir  = st.shift;
                                `IOEXP_CMD_OD_MASK: next_st.od_mask = st.shift;
                                `IOEXP_CMD_PP_MASK: next_st.pp_mask = st.shift;
                                default: begin
                                end
                            endcase
                            next_st.ack_drv = 1'b1;
                            next_st.fsm     = ioexp_pkg::ST_ACK;
                        end
                    end
                end
                ioexp_pkg::ST_ACK: begin
                    // Ack held over one full clock pulse
                    if (scl_fall) begin
                        next_st.ack_drv = 1'b0;
                        if (st.rw) begin
                            next_st.shift   = rd_data;
                            next_st.sda_drv = ~rd_data[7];
                            next_st.bitcnt  = 4'h1;
                            next_st.fsm     = ioexp_pkg::ST_TX;
                        end else begin
                            next_st.fsm = ioexp_pkg::ST_RX;
                        end
                    end
                end
                ioexp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (st.bitcnt == 4'h8) begin
                            next_st.sda_drv = 1'b0;
                            next_st.fsm     = ioexp_pkg::ST_TXACK;
                        end else begin
                            next_st.shift   = {st.shift[6:0], 1'b0};
                            next_st.sda_drv = ~st.shift[6];
                            next_st.bitcnt  = st.bitcnt + 4'h1;
                        end
                    end
                end
                ioexp_pkg::ST_TXACK: begin
                    // Master nack ends the read; ack repeats the register
                    if (scl_rise) begin
                        next_st.fsm = sda ? ioexp_pkg::ST_IGNORE : ioexp_pkg::ST_ACK;
                    end
                end
                default: begin
                    next_st.fsm = ioexp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            st          <= '0;
            st.fsm      <= ioexp_pkg::ST_IDLE;
            st.scl_d    <= 1'b1;
            st.sda_d    <= 1'b1;
            st.boot     <= 1'b1;
            st.rw       <= 1'b1;
            st.od_dir   <= `IOEXP_DIR_RESET;
            st.pp_dir   <= `IOEXP_DIR_RESET;
            st.od_mask  <= `IOEXP_MASK_RESET;
            st.pp_mask  <= `IOEXP_MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change detection and pins

    ioexp_detect u_det_od (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_levels  (od_lvl),
        .i_dir     (st.od_dir),
        .i_mask    (st.od_mask),
        .i_snap    (st.snap_od),
        .o_pending (od_pend)
    );
    ioexp_detect u_det_pp (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_levels  (pp_lvl),
        .i_dir     (st.pp_dir),
        .i_mask    (st.pp_mask),
        .i_snap    (st.snap_pp),
        .o_pending (pp_pend)
    );

    // Alert is open-drain: only ever driven low
    assign o_change_alert_n    = 1'b0;
    assign o_change_alert_n_oe = od_pend | pp_pend;
    assign o_sda               = 1'b0;
    assign o_sda_oe            = st.ack_drv | st.sda_drv;
    assign o_open_drain_pins    = 8'h00;
    assign o_open_drain_pins_oe = ~st.od_dir & ~st.od_out;
    assign o_push_pull_pins     = st.pp_out;
    assign o_push_pull_pins_oe  = ~st.pp_dir;

endmodule

/* inc/ioexp_regs.svh */
`ifndef IOEXP_REGS_SVH
`define IOEXP_REGS_SVH

// Command byte values, low three bits
`define IOEXP_CMD_OD_LEVELS      3'h0
`define IOEXP_CMD_PP_LEVELS      3'h1
`define IOEXP_CMD_OD_OUT         3'h2
`define IOEXP_CMD_PP_OUT         3'h3
`define IOEXP_CMD_OD_DIR         3'h4
`define IOEXP_CMD_PP_DIR         3'h5
`define IOEXP_CMD_OD_MASK        3'h6
`define IOEXP_CMD_PP_MASK        3'h7
`define IOEXP_CMD_LAST           8'h07

// Reset values
`define IOEXP_DIR_RESET          8'h00
`define IOEXP_MASK_RESET         8'h00
`define IOEXP_NIBBLE_ONES        4'hf
`define IOEXP_NIBBLE_ZEROS       4'h0

// Fixed upper slave address bits
`define IOEXP_ADDR_FIXED         5'h16

// Timing
`define IOEXP_CLK_MHZ            25
`define IOEXP_SPIKE_NS           50
`define IOEXP_SPIKE_CYC          ((`IOEXP_SPIKE_NS * `IOEXP_CLK_MHZ + 999) / 1000)
`define IOEXP_RELEASE_US         4
`define IOEXP_RELEASE_CYC        (`IOEXP_RELEASE_US * `IOEXP_CLK_MHZ)

`endif

/* inc/ioexp_pkg.sv */
package ioexp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RX,
        ST_TX,
        ST_TXACK,
        ST_IGNORE
    } ioexp_state_e;

    typedef logic [7:0] ioexp_byte_t;

endpackage

/* hw/ioexp_sync.sv */
`include "ioexp_regs.svh"

module ioexp_sync (
    input  wire logic i_mclk,
    input  wire logic i_reset,
    input  wire logic i_pin,
    output logic      o_level
);
    typedef struct packed {
        logic [2:0] taps;
        logic       level;
    } ioexp_sync_s;

    ioexp_sync_s st;
    ioexp_sync_s next_st;

    // Level moves once the later two taps agree; a one-sample spike never does
    // Latency kept short so the ack changes well inside a fast clock low phase
    always_comb begin
        next_st = st;
        next_st.taps = {st.taps[1:0], i_pin};
        if (st.taps[2] == st.taps[1]) begin
            next_st.level = st.taps[2];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            // Start from the pin so address selects are right at the first load
            st <= '{taps: {3{i_pin}}, level: i_pin};
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
endmodule

/* hw/ioexp_detect.sv */
module ioexp_detect (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_levels,
    input  wire logic [7:0] i_dir,
    input  wire logic [7:0] i_mask,
    input  wire logic       i_snap,
    output logic            o_pending
);
    typedef struct packed {
        logic [7:0] ref_lvl;
        logic       pending;
    } ioexp_det_s;

    ioexp_det_s st;
    ioexp_det_s next_st;
    logic [7:0] watched;

    // Only unmasked inputs compare; outputs never raise a change
    assign watched = i_dir & ~i_mask;

    always_comb begin
        next_st = st;
        if (i_snap) begin
            next_st.ref_lvl = i_levels;
            next_st.pending = 1'b0;
        end
        // Pins not watched track their level so enabling later is quiet
        next_st.ref_lvl = (next_st.ref_lvl & watched) | (i_levels & ~watched);
        if (|((i_levels ^ st.ref_lvl) & watched) && !i_snap) begin
            next_st.pending = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            st <= '{ref_lvl: 8'h00, pending: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_pending = st.pending;
endmodule

/* verification/ioexp_monitor.sv */
module ioexp_monitor (
    input wire logic       i_mclk,
    input wire logic       i_reset,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda,
    input wire logic       o_sda_oe,
    input wire logic       i_bus_reset_n,
    input wire logic       i_address_select_low,
    input wire logic       i_address_select_high,
    input wire logic [7:0] i_open_drain_pins,
    input wire logic [7:0] o_open_drain_pins,
    input wire logic [7:0] o_open_drain_pins_oe,
    input wire logic [7:0] i_push_pull_pins,
    input wire logic [7:0] o_push_pull_pins,
    input wire logic [7:0] o_push_pull_pins_oe,
    input wire logic       o_change_alert_n,
    input wire logic       o_change_alert_n_oe
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    logic [7:0] prev_od;
    logic [7:0] prev_pp;
    logic [3:0] quiet;
    logic [7:0] sel_pat;

    assign sel_pat = {{4{i_address_select_high}}, {4{i_address_select_low}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since a pin moved; an alert with no recent cause is a fault
    always_ff @(posedge i_mclk) begin
        prev_od <= i_open_drain_pins;
        prev_pp <= i_push_pull_pins;
        if (i_reset || prev_od != i_open_drain_pins || prev_pp != i_push_pull_pins) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    pp_dir_reset_a: assert property ($fell(i_reset) |-> ##[1:8] o_push_pull_pins_oe == 8'hff)
        else $error("push-pull pins not driven after reset");
    od_out_reset_a: assert property ($fell(i_reset) |-> ##[1:8] o_open_drain_pins_oe == ~sel_pat)
        else $error("open-drain reset pattern wrong");
    pp_out_reset_a: assert property ($fell(i_reset) |-> ##[1:8] o_push_pull_pins == sel_pat)
        else $error("push-pull reset pattern wrong");
    bus_reset_idle_a: assert property (!i_bus_reset_n [*8] |-> !o_sda_oe)
        else $error("data line held during bus reset");
    drain_only_a: assert property (o_open_drain_pins == 8'h00 && !o_sda && !o_change_alert_n)
        else $error("open-drain output drives high");
    ack_stands_a: assert property ($changed(o_sda_oe) && i_bus_reset_n |-> !i_scl)
        else $error("data line changed while clock high");
    alert_clear_a: assert property ($fell(o_change_alert_n_oe) |-> o_sda_oe)
        else $error("alert released outside an acknowledge");
    alert_cause_a: assert property ($rose(o_change_alert_n_oe) |-> quiet < 4'hc)
        else $error("alert raised with no pin change");
    alert_latch_a: assert property (o_change_alert_n_oe && !o_sda_oe |=> o_change_alert_n_oe)
        else $error("alert dropped without a read");

    ack_seen_c: cover property ($rose(o_sda_oe));
    alert_set_c: cover property ($rose(o_change_alert_n_oe));
    alert_clear_c: cover property ($fell(o_change_alert_n_oe));
endmodule

bind ioexp_top ioexp_monitor u_monitor (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_bus_reset_n(i_bus_reset_n),
    .i_address_select_low(i_address_select_low),
    .i_address_select_high(i_address_select_high),
    .i_open_drain_pins(i_open_drain_pins), .o_open_drain_pins(o_open_drain_pins),
    .o_open_drain_pins_oe(o_open_drain_pins_oe), .i_push_pull_pins(i_push_pull_pins),
    .o_push_pull_pins(o_push_pull_pins), .o_push_pull_pins_oe(o_push_pull_pins_oe),
    .o_change_alert_n(o_change_alert_n), .o_change_alert_n_oe(o_change_alert_n_oe)
);

/* verification/ioexp_master.sv */
module ioexp_master (
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low,
    output logic [7:0] o_res,
    output logic      o_res_stb
);
    timeunit 1ns;
    timeprecision 1ns;

    // Clock stands high between frames; 320 ns bits, faster than the bus limit to keep runs short
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_res = 8'h00;
        o_res_stb = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // Data moves mid-low so it stays put past the slave's filtered sampling point
    task automatic bit_io(input logic b, output logic s);
        wait_n(2);
        o_sda_low <= ~b;
        wait_n(4);
        o_scl <= 1'b1;
        wait_n(2);
        s = i_sda;
        o_scl <= 1'b0;
    endtask

    task automatic emit(input logic [7:0] v);
        o_res <= v;
        o_res_stb <= 1'b1;
        wait_n(1);
        o_res_stb <= 1'b0;
    endtask

    task automatic start();
        wait_n(2);
        o_sda_low <= 1'b0;
        wait_n(4);
        o_scl <= 1'b1;
        wait_n(4);
        o_sda_low <= 1'b1;
        wait_n(4);
        o_scl <= 1'b0;
    endtask

    task automatic stop();
        wait_n(2);
        o_sda_low <= 1'b1;
        wait_n(4);
        o_scl <= 1'b1;
        wait_n(4);
        o_sda_low <= 1'b0;
        wait_n(40);
    endtask

    task automatic spike();
        wait_n(3);
        o_scl <= 1'b1;
        wait_n(1);
        o_scl <= 1'b0;
    endtask

    task automatic send(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        emit({7'h00, s});
    endtask

    task automatic recv(input logic last);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
        emit(d);
    endtask
endmodule

/* verification/test_i2c_sixteen_bit_io_expander.sv */
module test_i2c_sixteen_bit_io_expander;
    timeunit 1ns;
    timeprecision 1ns;

    logic       i_mclk, i_reset, bus_rst_n, sel_lo, sel_hi;
    logic       scl, sda_low, sda_line, sda_out, sda_oe;
    logic       al_out, al_oe, alert_n, res_stb;
    logic [7:0] od_ext, od_out, od_oe, od_line;
    logic [7:0] pp_ext, pp_out, pp_oe, pp_line, res;
    logic [7:0] shadow [8];
    logic [7:0] notes [$];
    logic [6:0] a;
    int         n_errors, cmp_count, cycles;

    // Pull-ups on the bus, the alert line and the open-drain group
    assign sda_line = !(sda_low || (sda_oe && !sda_out));
    assign alert_n  = !(al_oe && !al_out);
    assign od_line  = od_ext & ~(od_oe & ~od_out);
    assign pp_line  = (pp_oe & pp_out) | (~pp_oe & pp_ext);

    ioexp_top dut (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_line),
        .o_sda(sda_out), .o_sda_oe(sda_oe), .i_bus_reset_n(bus_rst_n),
        .i_address_select_low(sel_lo), .i_address_select_high(sel_hi),
        .i_open_drain_pins(od_line), .o_open_drain_pins(od_out), .o_open_drain_pins_oe(od_oe),
        .i_push_pull_pins(pp_line), .o_push_pull_pins(pp_out), .o_push_pull_pins_oe(pp_oe),
        .o_change_alert_n(al_out), .o_change_alert_n_oe(al_oe)
    );
    ioexp_master m (
        .i_mclk(i_mclk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(sda_low),
        .o_res(res), .o_res_stb(res_stb)
    );

    always #20 i_mclk = ~i_mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Counts: %0d compares, %0d errors", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic alert_is(input logic e);
        repeat (10) @(posedge i_mclk);
        check({7'h00, alert_n}, {7'h00, e});
    endtask

    task automatic wr(input logic [6:0] ad, input logic [2:0] c, input logic [7:0] d,
                      input logic sp);
        repeat (3) notes.push_back(8'h00);
        m.start();
        m.send({ad, 1'b0});
        if (sp) m.spike();
        m.send({5'h00, c});
        m.send(d);
        m.stop();
    endtask

    task automatic rd(input logic [6:0] ad, input logic [2:0] c, input logic [7:0] e);
        repeat (3) notes.push_back(8'h00);
        notes.push_back(e);
        m.start();
        m.send({ad, 1'b0});
        m.send({5'h00, c});
        m.start();
        m.send({ad, 1'b1});
        m.recv(1'b1);
        m.stop();
    endtask

    // A refused address gets no acknowledge; a refused command only on its byte
    task automatic refuse(input logic [6:0] ad, input logic bad_cmd);
        if (bad_cmd) notes.push_back(8'h00);
        notes.push_back(8'h01);
        m.start();
        m.send({ad, 1'b0});
        if (bad_cmd) m.send(8'h08);
        m.stop();
    endtask

    task automatic pulse(input logic g, input int b);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_mclk);
            if (g) pp_ext[b] <= ~pp_ext[b];
            else od_ext[b] <= ~od_ext[b];
            repeat (5) @(posedge i_mclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_mclk) begin
        if (res_stb === 1'b1) check(res, (notes.size() > 0) ? notes.pop_front() : 8'hxx);
    end

    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        i_mclk = 1'b0;
        i_reset = 1'b1;
        bus_rst_n = 1'b1;
        {sel_hi, sel_lo} = 2'b00;
        od_ext = 8'hff;
        pp_ext = 8'h00;
        n_errors = 0;
        cmp_count = 0;
        cycles = 0;
        void'($urandom(14));
        for (int s = 0; s < 4; s++) begin
            @(posedge i_mclk);
            i_reset <= 1'b1;
            {sel_hi, sel_lo} <= 2'(s);
            repeat (10) @(posedge i_mclk);
            i_reset <= 1'b0;
            repeat (12) @(posedge i_mclk);
            a = {5'h16, 2'(s)};
            shadow[2] = {{4{sel_hi}}, {4{sel_lo}}};
            rd(a, 3'h2, shadow[2]);
            rd(a, 3'h3, shadow[2]);
            for (int c = 4; c < 8; c++) rd(a, 3'(c), 8'h00);
            refuse(a ^ 7'h01, 1'b0);
            refuse(a ^ 7'h08, 1'b0);
            check(od_oe, ~shadow[2]);
            check(pp_oe, 8'hff);
            $display("Test reset with selects %0d done", s);
        end
        pp_ext <= 8'($urandom);
        shadow[2] = 8'h5a;
        wr(a, 3'h2, shadow[2], 1'b1);
        for (int c = 3; c < 8; c++) begin
            shadow[c] = 8'($urandom);
            wr(a, 3'(c), shadow[c], 1'b0);
        end
        wr(a, 3'h0, 8'h00, 1'b0);
        for (int c = 2; c < 8; c++) rd(a, 3'(c), shadow[c]);
        rd(a, 3'h0, od_ext & (shadow[4] | shadow[2]));
        rd(a, 3'h1, (~shadow[5] & shadow[3]) | (shadow[5] & pp_ext));
        refuse(a, 1'b1);
        $display("Test register access done");
        wr(a, 3'h4, 8'hff, 1'b0);
        wr(a, 3'h6, 8'h00, 1'b0);
        wr(a, 3'h5, 8'hff, 1'b0);
        wr(a, 3'h7, 8'h00, 1'b0);
        rd(a, 3'h0, od_ext);
        rd(a, 3'h1, pp_ext);
        alert_is(1'b1);
        pulse(1'b0, 3);
        alert_is(1'b0);
        rd(a, 3'h1, pp_ext);
        alert_is(1'b0);
        rd(a, 3'h0, od_ext);
        alert_is(1'b1);
        wr(a, 3'h6, 8'h08, 1'b0);
        pulse(1'b0, 3);
        alert_is(1'b1);
        pulse(1'b1, 0);
        alert_is(1'b0);
        // Bus reset after the address: the half-done transfer must be forgotten
        notes.push_back(8'h00);
        m.start();
        m.send({a, 1'b0});
        bus_rst_n <= 1'b0;
        repeat (13) @(posedge i_mclk);
        bus_rst_n <= 1'b1;
        notes.push_back(8'h01);
        m.send(8'h02);
        m.stop();
        alert_is(1'b0);
        rd(a, 3'h3, shadow[3]);
        alert_is(1'b1);
        wr(a, 3'h5, 8'h00, 1'b0);
        wr(a, 3'h3, ~shadow[3], 1'b0);
        alert_is(1'b1);
        check(pp_out, ~shadow[3]);
        check(8'(notes.size()), 8'h00);
        $display("Test change alert done");
        end_of_test();
    end
endmodule
